// ---- common/tsc_pkg.sv ----
// shared constants and types for the time-stamp counter unit
package tsc_pkg;

  // model register addresses
  localparam logic [31:0] TSC_ADDR_COUNT     = 32'h0000_0010;
  localparam logic [31:0] TSC_ADDR_OFFSET    = 32'h0000_003b;
  localparam logic [31:0] TSC_ADDR_SIGNATURE = 32'hc000_0103;

  // reset values
  localparam logic [63:0] TSC_COUNT_RST     = 64'h0;
  localparam logic [63:0] TSC_OFFSET_RST    = 64'h0;
  localparam logic [31:0] TSC_SIGNATURE_RST = 32'h0;

  // capability and control bit positions
  localparam int TSC_CAP_LEAF1_EDX_BIT    = 4;
  localparam int TSC_CAP_LEAF7_EBX_BIT    = 1;
  localparam int TSC_CAP_EXT7_EDX_BIT     = 8;
  localparam int TSC_CAP_EXT1_EDX_BIT     = 27;
  localparam int TSC_CTRL_READ_DIS_BIT    = 2;

  // fixed-rate tick divider default (core clocks per tick)
  localparam logic [7:0] TSC_FIXED_DIV_RST = 8'h01;

  typedef enum logic [1:0] {
    TSC_RATE_CORE,
    TSC_RATE_FIXED
  } tsc_rate_t;

  // register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [63:0] wdata;
  } tsc_reg_req_t;

  // register access answer
  typedef struct packed {
    logic        ack;
    logic        fault;
    logic [63:0] rdata;
  } tsc_reg_rsp_t;

  // counter read answer
  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [63:0] count;
    logic [31:0] signature;
  } tsc_read_rsp_t;

  typedef struct packed {
    logic [31:0] leaf1_edx;
    logic [31:0] leaf7_ebx;
    logic [31:0] ext1_edx;
    logic [31:0] ext7_edx;
  } tsc_caps_t;

endpackage

// ---- hdl/tsc_unit.sv ----
// time-stamp counter with offset tracking and signature register
//
// Notes on behaviour
// - 64-bit counter, cleared by reset
// - keeps counting through halt and clock-stop
// - deep sleep may stop counting
// - legacy mode counts every core clock
// - constant mode counts fixed-rate ticks
// - invariant mode constant always, capability reported
// - reads never decrease except on wrap, counter write or offset write
// - read-disable limits reads to level zero
// - counter reads are not serialised
// - counter readable as model register 10h
// - legacy write loads low half, clears high
// - full write loads all 64 bits
// - 32-bit signature register, software written
// - combined read returns count and signature atomically
// - combined read gated, capability bit 27
// - writes touch only this processor's counter
// - separate 64-bit offset register at 3bh
// - offset register cleared by reset
// - counter write delta added to offset
// - offset write delta added to counter
// - offset changes only on writes
// - counter capability in leaf 1 bit 4
// - offset capability in leaf 7 bit 1
`timescale 1ns/1ps
module tsc_unit
  import tsc_pkg::*;
#(
  parameter bit INVARIANT  = 1'b1,
  parameter bit FULL_WRITE = 1'b1,
  parameter bit HAS_OFFSET = 1'b1,
  parameter bit HAS_SIGRD  = 1'b1
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // core state
  input  wire logic          clock_stop_request_n,
  input  wire logic          deep_sleep_n,
  input  wire logic          halted,
  input  wire logic          fixed_tick,
  input  wire tsc_rate_t     rate_mode,
  input  wire logic [31:0]   control_reg_four,
  input  wire logic [1:0]    priv_level,
  // counter read instructions
  input  wire logic          read_counter_op,
  input  wire logic          read_counter_and_signature_op,
  output tsc_read_rsp_t      read_rsp,
  // model register access
  input  wire tsc_reg_req_t  reg_req,
  output tsc_reg_rsp_t       reg_rsp,
  // capability words
  output tsc_caps_t          caps
);

  ////////////////////////////////////////////////////////////////////////
  logic [63:0] tick_counter;
  logic [63:0] timestamp_offset_track;
  logic [31:0] timestamp_signature;
  logic        user_read_disable;
  logic        tick_en;
  logic        wr_count;
  logic        wr_offset;
  logic        wr_sig;
  logic [63:0] next_count_w;
  logic [63:0] count_delta;
  logic [63:0] offset_delta;
  logic        read_ok;
  logic        addr_hit;

  assign user_read_disable = control_reg_four[TSC_CTRL_READ_DIS_BIT];

  ////////////////////////////////////////////////////////////////////////
  // tick source; halt and clock-stop are deliberately ignored
  always_comb begin
    unique case (rate_mode)
      TSC_RATE_CORE:  tick_en = 1'b1;
      TSC_RATE_FIXED: tick_en = fixed_tick;
      default:        tick_en = 1'b1;
    endcase
    // invariant part: fixed rate in every power state
    if (INVARIANT)
      tick_en = fixed_tick;
    // deep sleep stops counting unless invariant
    else if (!deep_sleep_n)
      tick_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode
  assign wr_count  = reg_req.wr && reg_req.addr == TSC_ADDR_COUNT;
  assign wr_offset = HAS_OFFSET && reg_req.wr &&
                     reg_req.addr == TSC_ADDR_OFFSET;
  assign wr_sig    = HAS_SIGRD && reg_req.wr &&
                     reg_req.addr == TSC_ADDR_SIGNATURE;
  assign addr_hit  = reg_req.addr == TSC_ADDR_COUNT ||
                     (HAS_OFFSET && reg_req.addr == TSC_ADDR_OFFSET) ||
                     (HAS_SIGRD && reg_req.addr == TSC_ADDR_SIGNATURE);

  // value written to the counter, legacy loads only low half
  assign next_count_w = FULL_WRITE ? reg_req.wdata
                        : {32'h0, reg_req.wdata[31:0]};
  // delta is against the count seen by the write itself
  assign count_delta  = next_count_w - tick_counter;
  assign offset_delta = reg_req.wdata - timestamp_offset_track;

  ////////////////////////////////////////////////////////////////////////
  // counter: only this unit's writes reach it
  always_ff @(posedge sys_clk) begin
    if (rst)
      tick_counter <= TSC_COUNT_RST;
    else if (wr_count)
      tick_counter <= next_count_w;
    else if (wr_offset)
      // offset delta carried into count, plus this cycle's tick
      tick_counter <= tick_counter + offset_delta
                      + {63'h0, tick_en};
    else if (tick_en)
      tick_counter <= tick_counter + 64'h1;
  end

  // offset follows writes only, never time
  always_ff @(posedge sys_clk) begin
    if (rst)
      timestamp_offset_track <= TSC_OFFSET_RST;
    else if (wr_offset)
      timestamp_offset_track <= reg_req.wdata;
    else if (wr_count && HAS_OFFSET)
      timestamp_offset_track <= timestamp_offset_track
                                + count_delta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      timestamp_signature <= TSC_SIGNATURE_RST;
    else if (wr_sig)
      timestamp_signature <= reg_req.wdata[31:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // model register answers, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack   <= (reg_req.rd || reg_req.wr) && addr_hit;
      reg_rsp.fault <= (reg_req.rd || reg_req.wr) && !addr_hit;
      reg_rsp.rdata <= 64'h0;
      if (reg_req.rd) begin
        if (reg_req.addr == TSC_ADDR_COUNT)
          reg_rsp.rdata <= tick_counter;
        else if (HAS_OFFSET && reg_req.addr == TSC_ADDR_OFFSET)
          reg_rsp.rdata <= timestamp_offset_track;
        else if (HAS_SIGRD && reg_req.addr == TSC_ADDR_SIGNATURE)
          reg_rsp.rdata <= {32'h0, timestamp_signature};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction reads sample the live count with no ordering wait;
  // a one-cycle sample of a counter that only rises keeps reads
  // strictly increasing in core-rate mode with INVARIANT clear and deep_sleep_n high
  assign read_ok = !user_read_disable || priv_level == 2'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_rsp <= '0;
    end else begin
      read_rsp.valid     <= read_counter_op ||
                            (read_counter_and_signature_op && HAS_SIGRD);
      read_rsp.fault     <= (read_counter_op ||
                             read_counter_and_signature_op) &&
                            (!read_ok || (read_counter_and_signature_op
                                          && !HAS_SIGRD));
      read_rsp.count     <= read_ok ? tick_counter : 64'h0;
      // both words captured on the same edge
      read_rsp.signature <= (read_ok && read_counter_and_signature_op)
                            ? timestamp_signature : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capability words
  always_comb begin
    caps = '0;
    caps.leaf1_edx[TSC_CAP_LEAF1_EDX_BIT] = 1'b1;
    caps.leaf7_ebx[TSC_CAP_LEAF7_EBX_BIT] = HAS_OFFSET;
    caps.ext7_edx[TSC_CAP_EXT7_EDX_BIT]   = INVARIANT;
    caps.ext1_edx[TSC_CAP_EXT1_EDX_BIT]   = HAS_SIGRD;
  end

  // halted and clock_stop_request_n intentionally do not gate tick_en
  logic unused_inputs;
  assign unused_inputs = halted ^ clock_stop_request_n;

endmodule

// ---- testbench/tsc_unit_asserts.sv ----
// port checker for the time-stamp counter unit
`timescale 1ns/1ps
module tsc_unit_asserts
  import tsc_pkg::*;
(
  // clock, reset and core state
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic [31:0]   control_reg_four,
  input wire logic [1:0]    priv_level,
  // requests and answers
  input wire logic          read_counter_op,
  input wire logic          read_counter_and_signature_op,
  input wire tsc_read_rsp_t read_rsp,
  input wire tsc_reg_req_t  reg_req,
  input wire tsc_reg_rsp_t  reg_rsp,
  input wire tsc_caps_t     caps
);
  logic req;
  logic hit;
  logic op;
  logic deny;
  assign req = reg_req.rd | reg_req.wr;
  assign hit = reg_req.addr == TSC_ADDR_COUNT
    || reg_req.addr == TSC_ADDR_OFFSET || reg_req.addr == TSC_ADDR_SIGNATURE;
  assign op = read_counter_op | read_counter_and_signature_op;
  assign deny = control_reg_four[2] && priv_level != 2'h0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  reg_hit_ack_a: assert property (req && hit |=> reg_rsp.ack)
    else $error("mapped access not acknowledged");
  reg_miss_fault_a: assert property (req && !hit |=>
    reg_rsp.fault && !reg_rsp.ack && reg_rsp.rdata == 64'h0)
    else $error("unmapped access not refused");
  read_answer_a: assert property (op |=> read_rsp.valid)
    else $error("read answer missing");
  read_deny_a: assert property (op && deny |=>
    read_rsp.fault && read_rsp.count == 64'h0)
    else $error("user read not refused");
  read_allow_a: assert property (op && !deny |=> !read_rsp.fault)
    else $error("allowed read refused");
  read_quiet_a: assert property (!op |=> !read_rsp.valid)
    else $error("read answer without request");
  caps_bits_a: assert property (caps.leaf1_edx[4] && caps.leaf7_ebx[1]
    && caps.ext7_edx[8] && caps.ext1_edx[27])
    else $error("capability bit clear");
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    reg_rsp == '0 && read_rsp == '0)
    else $error("answers not cleared by reset");

  reg_read_c: cover property (reg_req.rd && hit);
  deny_read_c: cover property (op && deny);
  sig_read_c: cover property (read_counter_and_signature_op && !deny);
endmodule

bind tsc_unit tsc_unit_asserts chk (.sys_clk, .rst, .control_reg_four,
  .priv_level, .read_counter_op, .read_counter_and_signature_op,
  .read_rsp, .reg_req, .reg_rsp, .caps);

// ---- testbench/tsc_unit_tb.sv ----
// self-checking bench for the time-stamp counter unit
`timescale 1ns/1ps
module tsc_unit_tb
  import tsc_pkg::*;
;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic          clock_stop_request_n = 1'b1;
  logic          halted = 1'b0;
  logic          fixed_tick = 1'b0;
  logic [31:0]   control_reg_four = 32'h0;
  logic [1:0]    priv_level = 2'h3;
  logic          read_counter_op = 1'b0;
  logic          read_counter_and_signature_op = 1'b0;
  tsc_reg_req_t  reg_req = '0;
  tsc_read_rsp_t read_rsp;
  tsc_reg_rsp_t  reg_rsp;
  int            bad_count = 0;
  int            tests_run = 0;
  int            cycles = 0;

  tsc_unit uut (.sys_clk, .rst, .clock_stop_request_n, .deep_sleep_n(1'b1),
    .halted, .fixed_tick, .rate_mode(TSC_RATE_FIXED), .control_reg_four,
    .priv_level, .read_counter_op, .read_counter_and_signature_op,
    .read_rsp, .reg_req, .reg_rsp, .caps());

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // run is about 45 cycles; ceiling leaves ample slack
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_op(input logic wr, input logic [31:0] addr,
                        input logic [63:0] wdata, input logic [63:0] exp);
    logic hit;
    hit = addr == TSC_ADDR_COUNT || addr == TSC_ADDR_OFFSET
      || addr == TSC_ADDR_SIGNATURE;
    @(posedge sys_clk);
    reg_req <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(posedge sys_clk);
    reg_req <= '0;
    #1;
    chk({62'h0, reg_rsp.ack, reg_rsp.fault}, hit ? 64'h2 : 64'h1);
    if (!wr) chk(reg_rsp.rdata, exp);
  endtask

  task automatic rd_op(input logic both, input logic deny,
                       input logic [63:0] cnt, input logic [31:0] sig);
    @(posedge sys_clk);
    read_counter_op <= !both;
    read_counter_and_signature_op <= both;
    @(posedge sys_clk);
    read_counter_op <= 1'b0;
    read_counter_and_signature_op <= 1'b0;
    #1;
    chk({62'h0, read_rsp.valid, read_rsp.fault}, {62'h0, 1'b1, deny});
    chk(read_rsp.count, cnt);
    if (both) chk({32'h0, read_rsp.signature}, {32'h0, sig});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    reg_op(0, TSC_ADDR_COUNT, 0, 64'h0);
    reg_op(0, TSC_ADDR_OFFSET, 0, 64'h0);
    reg_op(1, TSC_ADDR_COUNT, 64'h1_0000_0100, 0);
    reg_op(0, TSC_ADDR_OFFSET, 0, 64'h1_0000_0100);
    reg_op(1, TSC_ADDR_OFFSET, 64'h1_0000_0150, 0);
    reg_op(0, TSC_ADDR_COUNT, 0, 64'h1_0000_0150);
    reg_op(1, TSC_ADDR_SIGNATURE, 64'habcd_1234, 0);
    rd_op(1, 0, 64'h1_0000_0150, 32'habcd_1234);
    @(posedge sys_clk);
    control_reg_four <= 32'h4;
    rd_op(0, 1, 0, 0);
    rd_op(1, 1, 0, 0);
    @(posedge sys_clk);
    priv_level <= 2'h0;
    rd_op(0, 0, 64'h1_0000_0150, 0);
    reg_op(0, 32'h0000_0011, 0, 64'h0);
    @(posedge sys_clk);
    halted <= 1'b1;
    clock_stop_request_n <= 1'b0;
    fixed_tick <= 1'b1;
    repeat (5) @(posedge sys_clk);
    fixed_tick <= 1'b0;
    rd_op(0, 0, 64'h1_0000_0155, 0);
    reg_op(0, TSC_ADDR_OFFSET, 0, 64'h1_0000_0150);
    reg_op(1, TSC_ADDR_COUNT, '1, 0);
    @(posedge sys_clk);
    fixed_tick <= 1'b1;
    @(posedge sys_clk);
    fixed_tick <= 1'b0;
    rd_op(0, 0, 64'h0, 0);
    finish_test();
  end
endmodule
